// ---- rtl/spei_pkg.sv ----
/*
  Package for the shared pin and event input block: widths, bit positions,
  instruction class counts and interrupt latch indexing.
  Assumes nothing of its surroundings.
*/
package spei_pkg;
  localparam int SPEI_NIB_W = 4;
  localparam int SPEI_ADDR_W = 8;
  localparam int SPEI_PC_W = 12;
  localparam int SPEI_PC_PAGE_HI = 11;
  localparam int SPEI_PC_PAGE_LO = 6;
  localparam int SPEI_PAGE_W = SPEI_PC_PAGE_HI - SPEI_PC_PAGE_LO + 1;
  localparam int SPEI_INT_N = 6;
  localparam int SPEI_PORT_W = 4;
  // Shared port positions
  localparam int SPEI_CNT_A_BIT = 3;
  localparam int SPEI_CNT_B_BIT = 1;
  localparam int SPEI_SCK_BIT = 2;
  localparam int SPEI_SO_BIT = 1;
  localparam int SPEI_SI_BIT = 0;
  // Instruction classes
  localparam int SPEI_OPS_TOTAL = 90;
  localparam int SPEI_OPS_1B1C = 40;
  localparam int SPEI_OPS_1B2C = 11;
  localparam int SPEI_OPS_2B2C = 39;
  localparam logic [1:0] SPEI_ONE_BYTE = 2'h1;
  localparam logic [1:0] SPEI_TWO_BYTES = 2'h2;
  localparam logic [1:0] SPEI_ONE_CYCLE = 2'h1;
  localparam logic [1:0] SPEI_TWO_CYCLES = 2'h2;
  localparam int SPEI_MIN_PHASE_CYC = 2;
  localparam logic [1:0] SPEI_SYNC_RST = 2'h0;
  localparam logic SPEI_LATCH_RST = 1'b0;
  // Shift clock line idles high; its detector must reset to that level
  localparam logic SPEI_SCK_IDLE = 1'b1;

  typedef enum logic [1:0] {
    SPEI_CLS_1B1C = 2'h0,
    SPEI_CLS_1B2C = 2'h1,
    SPEI_CLS_2B2C = 2'h3
  } spei_cls_t;

  // Operation index 0..39 single byte fast, 40..50 single byte slow, rest two byte
  function automatic spei_cls_t spei_class(input logic [6:0] op);
    if (op < 7'(SPEI_OPS_1B1C))
      return SPEI_CLS_1B1C;
    else if (op < 7'(SPEI_OPS_1B1C + SPEI_OPS_1B2C))
      return SPEI_CLS_1B2C;
    else
      return SPEI_CLS_2B2C;
  endfunction
endpackage

// ---- rtl/spei_edge_if.sv ----
/*
  Interface carrying one synchronised input and its rising edge pulse.
  Assumes a single clock domain shared by both ends.
*/
`timescale 1ns/10ps
interface spei_edge_if;
  logic level;
  logic rise;
  modport det (output level, output rise);
  modport use_end (input level, input rise);
endinterface

// ---- rtl/spei_edge_det.sv ----
/*
  Two-stage synchroniser with rising edge detector on the synchronised samples.
  Assumes the pin input is held per phase for more than two cycles.
*/
`timescale 1ns/10ps
module spei_edge_det
  import spei_pkg::*;
#(
  parameter logic IDLE_LVL = 1'b0
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic pin_i,
  spei_edge_if.det edge_o
);
  logic [1:0] sync;
  logic [1:0] next_sync;
  logic prev;
  logic next_prev;

  // First stage feeds only the second stage
  always_comb
  begin
    next_sync = {sync[0], pin_i};
    next_prev = sync[1];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // Reset to the pin's idle level so no false edge follows reset
      sync <= {2{IDLE_LVL}};
      prev <= IDLE_LVL;
    end
    else
    begin
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign edge_o.level = sync[1];
  assign edge_o.rise = sync[1] & ~prev;
endmodule // spei_edge_det

// ---- rtl/spei_top.sv ----
/*
  Shared pin event inputs: counting inputs, serial pin sharing, pair address,
  interrupt qualification, program counter page and instruction class decode.
  Assumes pins synchronous to clk_sys_i, one clock per instruction cycle.
*/
`timescale 1ns/10ps
module spei_top
  import spei_pkg::*;
#(
  parameter int INT_N = SPEI_INT_N
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic count_en_i,
  input wire logic serial_en_i,
  input wire logic [SPEI_PORT_W-1:0] port8_pin_i,
  input wire logic [SPEI_PORT_W-1:0] port8_latch_i,
  output logic [SPEI_PORT_W-1:0] port8_oe_o,
  output logic [SPEI_PORT_W-1:0] port8_in_o,
  input wire logic [SPEI_PORT_W-1:0] port9_pin_i,
  input wire logic [SPEI_PORT_W-1:0] port9_latch_i,
  output logic [SPEI_PORT_W-1:0] port9_oe_o,
  output logic [SPEI_PORT_W-1:0] port9_in_o,
  input wire logic sck_ext_i,
  input wire logic sck_drive_i,
  input wire logic sck_out_i,
  input wire logic so_data_i,
  output logic sck_rise_o,
  output logic si_data_o,
  input wire logic count_ack_a_i,
  input wire logic count_ack_b_i,
  output logic count_req_a_o,
  output logic count_req_b_o,
  input wire logic [INT_N-1:0] int_set_i,
  input wire logic [INT_N-1:0] int_clr_i,
  input wire logic master_int_set_i,
  input wire logic master_int_clr_i,
  input wire logic [INT_N-1:0] mask_wdata_i,
  input wire logic mask_we_i,
  output logic [INT_N-1:0] int_pending_o,
  output logic int_req_o,
  input wire logic [SPEI_NIB_W-1:0] pair_wdata_i,
  input wire logic upper_pair_we_i,
  input wire logic lower_pair_we_i,
  output logic [SPEI_ADDR_W-1:0] data_addr_o,
  input wire logic pc_step_i,
  input wire logic pc_page_we_i,
  input wire logic [SPEI_PAGE_W-1:0] pc_page_i,
  input wire logic pc_low_we_i,
  input wire logic [SPEI_PC_PAGE_LO-1:0] pc_low_i,
  output logic [SPEI_PC_W-1:0] pc_o,
  input wire logic [6:0] op_index_i,
  output logic [1:0] op_bytes_o,
  output logic [1:0] op_cycles_o,
  input wire logic test_i,
  output logic test_mode_o
);
  spei_edge_if cnt_a_if();
  spei_edge_if cnt_b_if();
  spei_edge_if sck_if();

  logic count_input_a;
  logic count_input_b;
  logic count_latch_a, next_count_latch_a;
  logic count_latch_b, next_count_latch_b;
  logic [INT_N-1:0] interrupt_request_latch, next_interrupt_request_latch;
  logic [INT_N-1:0] interrupt_enable_mask, next_interrupt_enable_mask;
  logic master_interrupt_enable, next_master_interrupt_enable;
  logic [SPEI_NIB_W-1:0] upper_pair_register, next_upper_pair_register;
  logic [SPEI_NIB_W-1:0] lower_pair_register, next_lower_pair_register;
  logic [SPEI_PC_W-1:0] pc, next_pc;
  logic [SPEI_PORT_W-1:0] p8_in, next_p8_in, p9_in, next_p9_in;
  logic si_data, next_si_data;
  logic [1:0] op_bytes, next_op_bytes, op_cycles, next_op_cycles;
  spei_cls_t cls;

  assign count_input_a = port8_pin_i[SPEI_CNT_A_BIT];
  assign count_input_b = port8_pin_i[SPEI_CNT_B_BIT];

  spei_edge_det u_cnt_a (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pin_i(count_input_a),
    .edge_o(cnt_a_if.det));
  spei_edge_det u_cnt_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pin_i(count_input_b),
    .edge_o(cnt_b_if.det));
  spei_edge_det #(.IDLE_LVL(SPEI_SCK_IDLE)) u_sck (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .pin_i(sck_ext_i),
    .edge_o(sck_if.det));

  assign cls = spei_class(op_index_i);

  always_comb
  begin
    // Set wins over acknowledge so no edge is lost
    next_count_latch_a = count_en_i & cnt_a_if.rise ? 1'b1 :
      (count_ack_a_i ? 1'b0 : count_latch_a);
    next_count_latch_b = count_en_i & cnt_b_if.rise ? 1'b1 :
      (count_ack_b_i ? 1'b0 : count_latch_b);
    next_interrupt_request_latch = (interrupt_request_latch & ~int_clr_i) | int_set_i;
    next_interrupt_enable_mask = mask_we_i ? mask_wdata_i : interrupt_enable_mask;
    next_master_interrupt_enable = master_int_set_i ? 1'b1 :
      (master_int_clr_i ? 1'b0 : master_interrupt_enable);
    next_upper_pair_register = upper_pair_we_i ? pair_wdata_i : upper_pair_register;
    next_lower_pair_register = lower_pair_we_i ? pair_wdata_i : lower_pair_register;
    next_pc = pc;
    if (pc_step_i)
      next_pc = pc + SPEI_PC_W'(1);
    if (pc_page_we_i)
      next_pc[SPEI_PC_PAGE_HI:SPEI_PC_PAGE_LO] = pc_page_i;
    if (pc_low_we_i)
      next_pc[SPEI_PC_PAGE_LO-1:0] = pc_low_i;
    // Pin readback; counting and serial pins still read their raw level
    next_p8_in = port8_pin_i;
    next_p9_in = port9_pin_i;
    next_si_data = port9_pin_i[SPEI_SI_BIT];
    next_op_bytes = op_bytes;
    next_op_cycles = op_cycles;
    unique case (cls)
      SPEI_CLS_1B1C:
      begin
        next_op_bytes = SPEI_ONE_BYTE;
        next_op_cycles = SPEI_ONE_CYCLE;
      end
      SPEI_CLS_1B2C:
      begin
        next_op_bytes = SPEI_ONE_BYTE;
        next_op_cycles = SPEI_TWO_CYCLES;
      end
      SPEI_CLS_2B2C:
      begin
        next_op_bytes = SPEI_TWO_BYTES;
        next_op_cycles = SPEI_TWO_CYCLES;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_latch_a <= SPEI_LATCH_RST;
      count_latch_b <= SPEI_LATCH_RST;
      interrupt_request_latch <= '0;
      interrupt_enable_mask <= '0;
      master_interrupt_enable <= 1'b0;
      upper_pair_register <= '0;
      lower_pair_register <= '0;
      pc <= '0;
      p8_in <= '0;
      p9_in <= '0;
      si_data <= 1'b0;
      op_bytes <= SPEI_ONE_BYTE;
      op_cycles <= SPEI_ONE_CYCLE;
    end
    else
    begin
      count_latch_a <= next_count_latch_a;
      count_latch_b <= next_count_latch_b;
      interrupt_request_latch <= next_interrupt_request_latch;
      interrupt_enable_mask <= next_interrupt_enable_mask;
      master_interrupt_enable <= next_master_interrupt_enable;
      upper_pair_register <= next_upper_pair_register;
      lower_pair_register <= next_lower_pair_register;
      pc <= next_pc;
      p8_in <= next_p8_in;
      p9_in <= next_p9_in;
      si_data <= next_si_data;
      op_bytes <= next_op_bytes;
      op_cycles <= next_op_cycles;
    end
  end

  // Open-drain: drive low where the latch holds zero, except counting pins while counting and serial pins in serial mode
  always_comb
  begin
    port8_oe_o = ~port8_latch_i;
    if (count_en_i)
    begin
      port8_oe_o[SPEI_CNT_A_BIT] = 1'b0;
      port8_oe_o[SPEI_CNT_B_BIT] = 1'b0;
    end
    port9_oe_o = ~port9_latch_i;
    if (serial_en_i)
    begin
      port9_oe_o[SPEI_SCK_BIT] = sck_drive_i & ~sck_out_i;
      port9_oe_o[SPEI_SO_BIT] = ~so_data_i;
      port9_oe_o[SPEI_SI_BIT] = 1'b0;
    end
  end

  assign port8_in_o = p8_in;
  assign port9_in_o = p9_in;
  assign si_data_o = si_data;
  assign sck_rise_o = serial_en_i & ~sck_drive_i & sck_if.rise;
  assign count_req_a_o = count_latch_a;
  assign count_req_b_o = count_latch_b;
  assign int_pending_o = interrupt_request_latch & interrupt_enable_mask;
  assign int_req_o = master_interrupt_enable & (|int_pending_o);
  assign data_addr_o = {upper_pair_register, lower_pair_register};
  assign pc_o = pc;
  assign op_bytes_o = op_bytes;
  assign op_cycles_o = op_cycles;
  // Test pin only reported; core must stay in normal mode while it is low
  assign test_mode_o = test_i;

  count_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    count_en_i && cnt_a_if.rise |=> count_req_a_o)
    else $error("count latch a not set after rising edge");
  count_edge_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(count_req_a_o) |-> $past(cnt_a_if.rise) && $past(count_en_i))
    else $error("count latch a set without edge");
  cnt_pin_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    count_en_i |-> !port8_oe_o[SPEI_CNT_A_BIT] && !port8_oe_o[SPEI_CNT_B_BIT])
    else $error("counting pin driven while counting");
  ser_pin_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !serial_en_i |-> port9_oe_o == ~port9_latch_i)
    else $error("serial pins not behaving as port");
  pair_addr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    upper_pair_we_i && lower_pair_we_i |=> data_addr_o == {2{$past(pair_wdata_i)}})
    else $error("pair address wrong");
  int_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    int_req_o |-> master_interrupt_enable && |(interrupt_request_latch
    & interrupt_enable_mask))
    else $error("interrupt without enable");
  int_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    int_set_i != '0 |=> (interrupt_request_latch & $past(int_set_i)) == $past(int_set_i))
    else $error("interrupt latch not set");
  pc_page_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    pc_page_we_i |=> pc_o[SPEI_PC_PAGE_HI:SPEI_PC_PAGE_LO] == $past(pc_page_i))
    else $error("page field not loaded");
  op_class_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    op_index_i >= 7'(SPEI_OPS_1B1C + SPEI_OPS_1B2C) && op_index_i < 7'(SPEI_OPS_TOTAL)
    |=> op_bytes_o == SPEI_TWO_BYTES && op_cycles_o == SPEI_TWO_CYCLES)
    else $error("two byte class wrong");
  op_fast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    op_index_i < 7'(SPEI_OPS_1B1C)
    |=> op_cycles_o == SPEI_ONE_CYCLE && op_bytes_o == SPEI_ONE_BYTE)
    else $error("one cycle class wrong");
  op_slow_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    op_index_i >= 7'(SPEI_OPS_1B1C) && op_index_i < 7'(SPEI_OPS_1B1C + SPEI_OPS_1B2C)
    |=> op_cycles_o == SPEI_TWO_CYCLES && op_bytes_o == SPEI_ONE_BYTE)
    else $error("one byte slow class wrong");
endmodule // spei_top

// ---- dv/spei_pulse_src.sv ----
/*
  Far-side model: counting pulse source, external shift clock and test pin tie.
  Assumes one clock and one pulse requested at a time through fire_i.
*/
`timescale 1ns/10ps
module spei_pulse_src #(
  parameter int HOLD = 3
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] fire_i,
  output logic [2:0] pins_o,
  output logic test_o
);
  logic [2:0] sel;
  int n;
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      n <= 0;
      sel <= 3'h0;
    end
    else if (n == 0 && fire_i != 3'h0)
    begin
      sel <= fire_i;
      n <= 2 * HOLD;
    end
    else if (n != 0)
      n <= n - 1;
  end
  // Pins change off the sampling edge; shift clock idles high, counters low
  always @(negedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      pins_o <= 3'h4;
    else
    begin
      pins_o[1:0] <= (n > HOLD) ? sel[1:0] : 2'h0;
      pins_o[2] <= !((n > HOLD) && sel[2]);
    end
  end
  // Held firmly low: a floating pin could select the factory test function
  assign test_o = 1'b0;
endmodule // spei_pulse_src

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for the shared pin event block.
  Assumes the pulse source model drives the counting and shift clock pins.
*/
`timescale 1ns/10ps
module tb_top;
  import spei_pkg::*;
  logic clk_sys_i, rst_i, count_en_i, serial_en_i, sck_drive_i, sck_out_i, so_data_i;
  logic count_ack_a_i, count_ack_b_i, master_int_set_i, master_int_clr_i, mask_we_i;
  logic upper_pair_we_i, lower_pair_we_i, pc_step_i, pc_page_we_i, pc_low_we_i;
  logic [3:0] port8_latch_i, port9_latch_i, pair_wdata_i, port8_oe_o, port8_in_o;
  logic [3:0] port9_oe_o, port9_in_o;
  logic [5:0] int_set_i, int_clr_i, mask_wdata_i, pc_page_i, pc_low_i, int_pending_o;
  logic [6:0] op_index_i;
  logic [2:0] fire;
  logic sck_rise_o, si_data_o, count_req_a_o, count_req_b_o, int_req_o, test_mode_o;
  logic [7:0] data_addr_o;
  logic [11:0] pc_o;
  logic [1:0] op_bytes_o, op_cycles_o;
  wire [2:0] pp;
  wire test_i;
  // Open-drain lines with pull-ups; the block pulls low where its enable is set
  wire [3:0] port8_pin_i = {pp[0], 1'b1, pp[1], 1'b1} & ~port8_oe_o;
  wire [3:0] port9_pin_i = {1'b1, pp[2], 2'h3} & ~port9_oe_o;
  wire sck_ext_i = port9_pin_i[2];
  int error_cnt = 0;
  int n_checks = 0;

  spei_pulse_src src (.clk_sys_i, .rst_i, .fire_i(fire), .pins_o(pp), .test_o(test_i));
  spei_top dut (.clk_sys_i, .rst_i, .count_en_i, .serial_en_i, .port8_pin_i, .port8_latch_i,
    .port8_oe_o, .port8_in_o, .port9_pin_i, .port9_latch_i, .port9_oe_o, .port9_in_o,
    .sck_ext_i, .sck_drive_i, .sck_out_i, .so_data_i, .sck_rise_o, .si_data_o,
    .count_ack_a_i, .count_ack_b_i, .count_req_a_o, .count_req_b_o, .int_set_i, .int_clr_i,
    .master_int_set_i, .master_int_clr_i, .mask_wdata_i, .mask_we_i, .int_pending_o,
    .int_req_o, .pair_wdata_i, .upper_pair_we_i, .lower_pair_we_i, .data_addr_o, .pc_step_i,
    .pc_page_we_i, .pc_page_i, .pc_low_we_i, .pc_low_i, .pc_o, .op_index_i, .op_bytes_o,
    .op_cycles_o, .test_i, .test_mode_o);

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic port_test();
    port8_latch_i = 4'h6;
    port9_latch_i = 4'h5;
    cyc(1);
    chk(port8_oe_o, 4'h9);
    chk(port9_oe_o, 4'ha);
    cyc(1);
    chk(port8_in_o, 4'h4);
    chk(port9_in_o, 4'h5);
    chk(si_data_o, 1'b1);
    {serial_en_i, sck_drive_i, sck_out_i, so_data_i} = 4'hc;
    cyc(1);
    chk(port9_oe_o[2:1], 2'h3);
    {sck_drive_i, so_data_i} = 2'h1;
    chk(test_mode_o, 1'b0);
  endtask

  task automatic count_pulse(input bit b);
    fire = b ? 3'h2 : 3'h1;
    cyc(1);
    fire = 3'h0;
    cyc(2);
    chk(b ? count_req_b_o : count_req_a_o, 1'b0);
    cyc(1);
    chk(b ? count_req_b_o : count_req_a_o, count_en_i);
    cyc(6);
    chk(b ? count_req_b_o : count_req_a_o, count_en_i);
    {count_ack_b_i, count_ack_a_i} = b ? 2'h2 : 2'h1;
    cyc(1);
    {count_ack_b_i, count_ack_a_i} = 2'h0;
    chk({count_req_b_o, count_req_a_o}, 2'h0);
  endtask

  task automatic sck_test();
    fire = 3'h4;
    cyc(1);
    fire = 3'h0;
    cyc(4);
    chk(sck_rise_o, 1'b0);
    cyc(1);
    chk(sck_rise_o, 1'b1);
    cyc(1);
    chk(sck_rise_o, 1'b0);
  endtask

  task automatic reg_test();
    {pair_wdata_i, upper_pair_we_i} = {4'ha, 1'b1};
    cyc(1);
    {pair_wdata_i, upper_pair_we_i, lower_pair_we_i} = {4'h3, 2'h1};
    cyc(1);
    {pair_wdata_i, upper_pair_we_i} = {4'h5, 1'b1};
    chk(data_addr_o, 8'ha3);
    cyc(1);
    {upper_pair_we_i, lower_pair_we_i} = 2'h0;
    chk(data_addr_o, 8'h55);
    {mask_wdata_i, mask_we_i, int_set_i} = {6'h24, 1'b1, 6'h21};
    cyc(1);
    {mask_we_i, int_set_i, master_int_set_i} = {1'b0, 6'h0, 1'b1};
    chk({int_pending_o, int_req_o}, {6'h20, 1'b0});
    cyc(1);
    {master_int_set_i, int_clr_i} = {1'b0, 6'h20};
    chk(int_req_o, 1'b1);
    cyc(1);
    {int_clr_i, mask_wdata_i, mask_we_i} = {6'h0, 6'h3f, 1'b1};
    chk({int_pending_o, int_req_o}, 7'h0);
    cyc(1);
    mask_we_i = 1'b0;
    chk(int_pending_o, 6'h01);
    {pc_page_i, pc_low_i, pc_page_we_i, pc_low_we_i} = {12'hfff, 2'h3};
    cyc(1);
    {pc_page_we_i, pc_low_we_i, pc_step_i} = 3'h1;
    chk(pc_o, 12'hfff);
    cyc(1);
    {pc_page_i, pc_page_we_i} = {6'h15, 1'b1};
    chk(pc_o, 12'h000);
    cyc(1);
    {pc_page_we_i, pc_step_i} = 2'h0;
    chk(pc_o, 12'h541);
  endtask

  task automatic op_test();
    int c0 = 0;
    int c1 = 0;
    int c2 = 0;
    for (int i = 0; i < SPEI_OPS_TOTAL; i++)
    begin
      op_index_i = 7'(i);
      cyc(1);
      if (op_bytes_o === SPEI_ONE_BYTE && op_cycles_o === SPEI_ONE_CYCLE)
        c0++;
      else if (op_bytes_o === SPEI_ONE_BYTE && op_cycles_o === SPEI_TWO_CYCLES)
        c1++;
      else if (op_bytes_o === SPEI_TWO_BYTES && op_cycles_o === SPEI_TWO_CYCLES)
        c2++;
    end
    chk(c0, SPEI_OPS_1B1C);
    chk(c1, SPEI_OPS_1B2C);
    chk(c2, SPEI_OPS_2B2C);
    chk(c0 + c1 + c2, SPEI_OPS_TOTAL);
  endtask

  // A hang ends the run through the same verdict path
  initial
  begin
    cyc(2000);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    rst_i = 1'b1;
    fire = 3'h0;
    {count_en_i, serial_en_i, sck_drive_i, sck_out_i, so_data_i, count_ack_a_i} = '0;
    {count_ack_b_i, master_int_set_i, master_int_clr_i, mask_we_i, pc_step_i} = '0;
    {upper_pair_we_i, lower_pair_we_i, pc_page_we_i, pc_low_we_i, op_index_i} = '0;
    {port8_latch_i, port9_latch_i, pair_wdata_i, int_set_i, int_clr_i} = '0;
    {mask_wdata_i, pc_page_i, pc_low_i} = '0;
    cyc(10);
    rst_i = 1'b0;
    port_test();
    count_en_i = 1'b1;
    count_pulse(1'b0);
    count_pulse(1'b1);
    count_en_i = 1'b0;
    count_pulse(1'b0);
    sck_test();
    reg_test();
    op_test();
    report_and_stop();
  end
endmodule // tb_top
